// [common/tcc_pkg.sv]
package tcc_pkg;

    // ------------------------------------------------------------
    // Register byte addresses (one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
    localparam logic [7:0] ADDR_CONTROL_TWO = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CAP1_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_CAP1_LOW = 8'h10;
    localparam logic [7:0] ADDR_CAP2_HIGH = 8'h14;
    localparam logic [7:0] ADDR_CAP2_LOW = 8'h18;
    localparam logic [7:0] ADDR_CMP1_HIGH = 8'h1C;
    localparam logic [7:0] ADDR_CMP1_LOW = 8'h20;
    localparam logic [7:0] ADDR_CMP2_HIGH = 8'h24;
    localparam logic [7:0] ADDR_CMP2_LOW = 8'h28;
    localparam logic [7:0] ADDR_CNT_HIGH = 8'h2C;
    localparam logic [7:0] ADDR_CNT_LOW = 8'h30;
    localparam logic [7:0] ADDR_ALT_HIGH = 8'h34;
    localparam logic [7:0] ADDR_ALT_LOW = 8'h38;
    // Distance between the two channels of capture or compare registers
    localparam logic [7:0] ADDR_CHANNEL_STRIDE = 8'h08;

    // ------------------------------------------------------------
    // Control register one fields
    // ------------------------------------------------------------
    localparam int CR1_CAPTURE_IRQ_ENABLE = 7;
    localparam int CR1_COMPARE_IRQ_ENABLE = 6;
    localparam int CR1_OVERFLOW_IRQ_ENABLE = 5;
    localparam int CR1_COMPARE_OUTPUT_LEVEL2 = 2;
    localparam int CR1_CAPTURE_EDGE_SELECT1 = 1;
    localparam int CR1_COMPARE_OUTPUT_LEVEL1 = 0;

    // ------------------------------------------------------------
    // Control register two fields
    // ------------------------------------------------------------
    localparam int CR2_COMPARE_OUTPUT_ENABLE1 = 7;
    localparam int CR2_COMPARE_OUTPUT_ENABLE2 = 6;
    localparam int CR2_ONE_PULSE_SELECT = 5;
    localparam int CR2_PWM_SELECT = 4;
    localparam int CR2_CLOCK_SELECT_BIT1 = 3;
    localparam int CR2_CLOCK_SELECT_BIT0 = 2;
    localparam int CR2_CAPTURE_EDGE_SELECT2 = 1;
    localparam int CR2_EXT_CLOCK_EDGE_SELECT = 0;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int SR_CAPTURE_FLAG1 = 7;
    localparam int SR_COMPARE_FLAG1 = 6;
    localparam int SR_OVERFLOW_FLAG = 5;
    localparam int SR_CAPTURE_FLAG2 = 4;
    localparam int SR_COMPARE_FLAG2 = 3;

    // ------------------------------------------------------------
    // Clock select encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] CLK_SEL_DIV4 = 2'h0;
    localparam logic [1:0] CLK_SEL_DIV2 = 2'h1;
    localparam logic [1:0] CLK_SEL_DIV8 = 2'h2;
    localparam logic [1:0] CLK_SEL_EXT = 2'h3;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNTER_RESET = 16'hFFFC;
    localparam logic [15:0] COUNTER_TOP = 16'hFFFF;
    localparam logic [15:0] COMPARE_RESET = 16'h8000;

    // ------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tcc_pkg

// [hw/tcc_top.sv]
// Operation
// R01: Both clock-select bits one makes the external clock pin drive the counter.
// R02: External-edge select bit picks rising or falling pin edges for counting.
// R03: All counter updates happen on the internal clock, external edges synchronised.
// R04: External clock leaves four CPU clock edges between its active edges.
// R05: Two 16-bit capture registers latch the counter on selected pin edges.
// R06: Capture registers are read-only high and low bytes; writes ignored.
// R07: Each capture input has its own edge-select bit, one per control register.
// R08: Capture sets flag and stores count; shared enable and global mask gate request.
// R09: Capture flag clears after status read seeing it, then capture low access.
// R10: Reading capture high blocks captures and flag until capture low is read.
// R11: Capture register holds the most recent capture, overwriting older values.
// R12: Capture and compare channels all work at once without interference.
// R13: In one-pulse or modulation mode only capture channel two captures.
// R14: Capture inputs always see pin transitions, whatever the pin direction.
// R15: Two read/write 16-bit compare registers, reset 8000h, compared continuously.
// R16: Match sets flag, drives level bit to pin, requests interrupt; pin low at reset.
// R17: Flag and pin act while counter equals compare value, in every clock mode.
// R18: Output enable clear leaves pin as general I/O; interrupt still possible.
// R19: Compare flag clears after status read seeing it, then compare low access.
// R20: Writing compare high suspends that channel's matching until low is written.
// R21: Software updates compare by high write, status read, then low write.
// R22: A 16-bit free-running up counter is observed by all channels.
// R23: Internal timer clock is CPU clock divided by 2, 4 or 8.
// R24: Writing counter low or alternate low reloads FFFCh, also the reset value.
`timescale 1ns/1ps

module tcc_top
    import tcc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_clock_pin,
    input wire logic [1:0] capture_input_pin,
    output logic [1:0] compare_output_pin,
    output logic [1:0] compare_output_pin_oe,
    input wire logic cpu_irq_mask,
    output logic timer_irq
);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic [7:0] rd_byte;
    logic rd_mapped;

    wire wr_do = aw_held & w_held & ~s_axi_bvalid;
    wire rd_do = s_axi_arvalid & s_axi_arready;
    wire wr_mapped = (aw_addr[1:0] == 2'h0) && (aw_addr <= ADDR_ALT_LOW);
    wire wr_en = wr_do & wr_mapped & w_lane0;
    wire [7:0] rd_addr = s_axi_araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_do) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] control_reg_one;
    logic [7:0] control_reg_two;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_reg_one <= CONTROL_RESET;
            control_reg_two <= CONTROL_RESET;
        end else if (wr_en && aw_addr == ADDR_CONTROL_ONE) begin
            control_reg_one <= w_byte;
        end else if (wr_en && aw_addr == ADDR_CONTROL_TWO) begin
            control_reg_two <= w_byte;
        end
    end

    wire [1:0] timer_clock_select = {control_reg_two[CR2_CLOCK_SELECT_BIT1],
                                     control_reg_two[CR2_CLOCK_SELECT_BIT0]};
    wire ext_clock_edge_select = control_reg_two[CR2_EXT_CLOCK_EDGE_SELECT];
    wire one_pulse_select = control_reg_two[CR2_ONE_PULSE_SELECT];
    wire pwm_select = control_reg_two[CR2_PWM_SELECT];
    wire capture_irq_enable = control_reg_one[CR1_CAPTURE_IRQ_ENABLE];
    wire compare_irq_enable = control_reg_one[CR1_COMPARE_IRQ_ENABLE];
    wire overflow_irq_enable = control_reg_one[CR1_OVERFLOW_IRQ_ENABLE];
    wire [1:0] capture_edge_select = {control_reg_two[CR2_CAPTURE_EDGE_SELECT2],
                                      control_reg_one[CR1_CAPTURE_EDGE_SELECT1]}; // R07
    wire [1:0] compare_output_level = {control_reg_one[CR1_COMPARE_OUTPUT_LEVEL2],
                                       control_reg_one[CR1_COMPARE_OUTPUT_LEVEL1]};
    wire [1:0] compare_output_enable = {control_reg_two[CR2_COMPARE_OUTPUT_ENABLE2],
                                        control_reg_two[CR2_COMPARE_OUTPUT_ENABLE1]};

    // ------------------------------------------------------------
    // Timer clock: prescaler and external clock edge
    // ------------------------------------------------------------
    logic [2:0] presc;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc <= 3'h0;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            presc <= presc + 3'h1;
            ext_s1 <= ext_clock_pin; // R03
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // Edge select high counts rising edges, low counts falling edges
    wire ext_edge = ext_clock_edge_select ? (ext_s2 & ~ext_s3) : (~ext_s2 & ext_s3); // R02
    logic tick;
    always_comb begin
        case (timer_clock_select)
            CLK_SEL_DIV2: tick = presc[0]; // R23
            CLK_SEL_DIV4: tick = &presc[1:0]; // R23
            CLK_SEL_DIV8: tick = &presc; // R23
            CLK_SEL_EXT: tick = ext_edge; // R01 R04
            default: tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Free-running counter and overflow
    // ------------------------------------------------------------
    logic [15:0] counter;
    logic overflow_flag;
    logic overflow_armed;
    wire status_rd = rd_do && rd_addr == ADDR_STATUS;
    wire cnt_low_rd = rd_do && rd_addr == ADDR_CNT_LOW;
    wire cnt_low_wr = wr_en && aw_addr == ADDR_CNT_LOW;
    wire alt_low_wr = wr_en && aw_addr == ADDR_ALT_LOW;
    wire counter_reload = cnt_low_wr | alt_low_wr;
    wire overflow_set = tick && counter == COUNTER_TOP && !counter_reload;
    wire overflow_clear = overflow_armed & (cnt_low_rd | cnt_low_wr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter <= COUNTER_RESET; // R24
        end else if (counter_reload) begin
            counter <= COUNTER_RESET; // R24
        end else if (tick) begin
            counter <= counter + 16'h0001; // R22 R03
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag <= 1'b0;
            overflow_armed <= 1'b0;
        end else begin
            overflow_flag <= overflow_set | (overflow_flag & ~overflow_clear);
            if (overflow_clear) begin
                overflow_armed <= 1'b0;
            end else if (status_rd && overflow_flag) begin
                overflow_armed <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Capture and compare channels
    // ------------------------------------------------------------
    logic [15:0] capture_value [2];
    logic [15:0] compare_value [2];
    logic [1:0] capture_flag;
    logic [1:0] compare_flag;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            localparam logic [7:0] OFS = ch[0] ? ADDR_CHANNEL_STRIDE : 8'h00;
            logic cap_s1;
            logic cap_s2;
            logic cap_s3;
            logic cap_blocked;
            logic cap_armed;
            logic [15:0] cap_val;
            logic cap_flag;
            logic [15:0] cmp_val;
            logic cmp_inhibit;
            logic cmp_armed;
            logic cmp_flag;
            logic pin_latch;
            logic pin_oe;

            wire cap_hi_rd = rd_do && rd_addr == ADDR_CAP1_HIGH + OFS;
            wire cap_lo_rd = rd_do && rd_addr == ADDR_CAP1_LOW + OFS;
            wire cap_lo_wr = wr_en && aw_addr == ADDR_CAP1_LOW + OFS;
            wire cmp_hi_wr = wr_en && aw_addr == ADDR_CMP1_HIGH + OFS;
            wire cmp_lo_wr = wr_en && aw_addr == ADDR_CMP1_LOW + OFS;
            wire cmp_lo_rd = rd_do && rd_addr == ADDR_CMP1_LOW + OFS;
            wire cap_allowed = (ch == 1) || !(one_pulse_select || pwm_select); // R13
            wire cap_edge = capture_edge_select[ch] ? (cap_s2 & ~cap_s3)
                                                    : (~cap_s2 & cap_s3);
            wire cap_event = cap_edge & cap_allowed & ~cap_blocked; // R10 R14
            wire cap_clear = cap_armed & (cap_lo_rd | cap_lo_wr); // R09
            wire cmp_match = (counter == cmp_val) && !cmp_inhibit; // R17 R20
            wire cmp_clear = cmp_armed & (cmp_lo_rd | cmp_lo_wr); // R19

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cap_s1 <= 1'b0;
                    cap_s2 <= 1'b0;
                    cap_s3 <= 1'b0;
                    cap_blocked <= 1'b0;
                    cap_val <= 16'h0000;
                end else begin
                    cap_s1 <= capture_input_pin[ch];
                    cap_s2 <= cap_s1;
                    cap_s3 <= cap_s2;
                    if (cap_hi_rd) begin
                        cap_blocked <= 1'b1; // R10
                    end else if (cap_lo_rd) begin
                        cap_blocked <= 1'b0; // R10
                    end
                    if (cap_event) begin
                        cap_val <= counter; // R05 R11 R12
                    end
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cap_flag <= 1'b0;
                    cap_armed <= 1'b0;
                end else begin
                    cap_flag <= cap_event | (cap_flag & ~cap_clear); // R08
                    if (cap_clear) begin
                        cap_armed <= 1'b0;
                    end else if (status_rd && cap_flag) begin
                        cap_armed <= 1'b1; // R09
                    end
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cmp_val <= COMPARE_RESET; // R15
                    cmp_inhibit <= 1'b0;
                end else if (cmp_hi_wr) begin
                    cmp_val[15:8] <= w_byte;
                    cmp_inhibit <= 1'b1; // R20 R21
                end else if (cmp_lo_wr) begin
                    cmp_val[7:0] <= w_byte;
                    cmp_inhibit <= 1'b0; // R20
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cmp_flag <= 1'b0;
                    cmp_armed <= 1'b0;
                    pin_latch <= 1'b0; // R16
                    pin_oe <= 1'b0;
                end else begin
                    cmp_flag <= cmp_match | (cmp_flag & ~cmp_clear); // R16 R17
                    if (cmp_clear) begin
                        cmp_armed <= 1'b0;
                    end else if (status_rd && cmp_flag) begin
                        cmp_armed <= 1'b1; // R19
                    end
                    if (cmp_match) begin
                        pin_latch <= compare_output_level[ch]; // R16 R17
                    end
                    pin_oe <= compare_output_enable[ch]; // R18
                end
            end

            assign capture_value[ch] = cap_val;
            assign capture_flag[ch] = cap_flag;
            assign compare_value[ch] = cmp_val;
            assign compare_flag[ch] = cmp_flag;
            assign compare_output_pin[ch] = pin_latch;
            assign compare_output_pin_oe[ch] = pin_oe;
        end
    endgenerate

    // ------------------------------------------------------------
    // Status and interrupt request
    // ------------------------------------------------------------
    logic [7:0] timer_status_reg;
    always_comb begin
        timer_status_reg = 8'h00;
        timer_status_reg[SR_CAPTURE_FLAG1] = capture_flag[0];
        timer_status_reg[SR_COMPARE_FLAG1] = compare_flag[0];
        timer_status_reg[SR_OVERFLOW_FLAG] = overflow_flag;
        timer_status_reg[SR_CAPTURE_FLAG2] = capture_flag[1];
        timer_status_reg[SR_COMPARE_FLAG2] = compare_flag[1];
    end

    // Pending requests stay in the flags until both enable and mask allow them
    wire irq_any = (capture_irq_enable & (|capture_flag))
                 | (compare_irq_enable & (|compare_flag))
                 | (overflow_irq_enable & overflow_flag);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= irq_any & ~cpu_irq_mask; // R08 R16 R18
        end
    end

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    always_comb begin
        rd_mapped = 1'b1;
        case (rd_addr)
            ADDR_CONTROL_ONE: rd_byte = control_reg_one;
            ADDR_CONTROL_TWO: rd_byte = control_reg_two;
            ADDR_STATUS: rd_byte = timer_status_reg;
            ADDR_CAP1_HIGH: rd_byte = capture_value[0][15:8]; // R06
            ADDR_CAP1_LOW: rd_byte = capture_value[0][7:0];
            ADDR_CAP2_HIGH: rd_byte = capture_value[1][15:8];
            ADDR_CAP2_LOW: rd_byte = capture_value[1][7:0];
            ADDR_CMP1_HIGH: rd_byte = compare_value[0][15:8];
            ADDR_CMP1_LOW: rd_byte = compare_value[0][7:0];
            ADDR_CMP2_HIGH: rd_byte = compare_value[1][15:8];
            ADDR_CMP2_LOW: rd_byte = compare_value[1][7:0];
            ADDR_CNT_HIGH: rd_byte = counter[15:8];
            ADDR_CNT_LOW: rd_byte = counter[7:0];
            ADDR_ALT_HIGH: rd_byte = counter[15:8];
            ADDR_ALT_LOW: rd_byte = counter[7:0];
            default: begin
                rd_byte = 8'h00;
                rd_mapped = 1'b0;
            end
        endcase
    end

endmodule : tcc_top

// [test/tcc_assertions.sv]
`timescale 1ns/1ps
module tcc_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] compare_output_pin,
    input wire logic [1:0] compare_output_pin_oe,
    input wire logic cpu_irq_mask,
    input wire logic timer_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
    a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while answering");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_irq_masked: assert property (cpu_irq_mask |=> !timer_irq)
        else $error("interrupt while masked");
    a_reset_idle: assert property ($rose(aresetn) |-> compare_output_pin == 2'h0 &&
        compare_output_pin_oe == 2'h0 && !timer_irq) else $error("outputs not idle at reset");
endmodule : tcc_checker

bind tcc_top tcc_checker u_chk (.*);

// [test/tcc_pins_model.sv]
`timescale 1ns/1ps
module tcc_pins_model (
    input wire logic aclk,
    output logic ext_clock_pin,
    output logic [1:0] capture_input_pin
);
    initial begin
        ext_clock_pin <= 1'b0;
        capture_input_pin <= 2'h0;
    end
    // Each half period lasts four CPU clocks
    task automatic ext_pulses(input int n);
        repeat (2 * n) begin
            repeat (4) @(posedge aclk);
            ext_clock_pin <= ~ext_clock_pin;
        end
        repeat (6) @(posedge aclk);
    endtask : ext_pulses
    task automatic cap_toggle(input int ch);
        capture_input_pin[ch] <= ~capture_input_pin[ch];
        repeat (6) @(posedge aclk);
    endtask : cap_toggle
endmodule : tcc_pins_model

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench import tcc_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic cpu_irq_mask;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic timer_irq, ext_clock_pin;
    logic [1:0] s_axi_bresp, s_axi_rresp, capture_input_pin, compare_output_pin;
    logic [1:0] compare_output_pin_oe;
    int num_errors = 0, tests_run = 0;
    tcc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clock_pin,
        .capture_input_pin, .compare_output_pin, .compare_output_pin_oe,
        .cpu_irq_mask, .timer_irq);
    tcc_pins_model u_pins (.aclk, .ext_clock_pin, .capture_input_pin);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, m, e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata & {24'h0, m}, {24'h0, e});
    endtask : rd
    task automatic conclude();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    initial begin
        forever #5 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        conclude();
    end
    initial begin
        cpu_irq_mask <= 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        s_axi_wstrb <= 4'hF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_CMP1_HIGH, 8'hFF, 8'h80);
        rd(ADDR_CMP2_LOW, 8'hFF, 8'h00);
        rd(8'h3C, 8'hFF, 8'h00);
        wr(8'h3C, 8'h55, RESP_SLVERR);
        wr(ADDR_CONTROL_TWO, 8'h0F, RESP_OKAY);
        wr(ADDR_CNT_LOW, 8'h00, RESP_OKAY);
        rd(ADDR_CNT_LOW, 8'hFF, 8'hFC);
        u_pins.ext_pulses(3);
        rd(ADDR_CNT_LOW, 8'hFF, 8'hFF);
        wr(ADDR_CONTROL_TWO, 8'h0E, RESP_OKAY);
        u_pins.ext_pulses(2);
        rd(ADDR_CNT_HIGH, 8'hFF, 8'h00);
        rd(ADDR_CNT_LOW, 8'hFF, 8'h01);
        wr(ADDR_CONTROL_ONE, 8'h02, RESP_OKAY);
        u_pins.cap_toggle(0);
        rd(ADDR_STATUS, 8'h90, 8'h80);
        rd(ADDR_CAP1_HIGH, 8'hFF, 8'h00);
        rd(ADDR_CAP1_LOW, 8'hFF, 8'h01);
        rd(ADDR_STATUS, 8'h80, 8'h00);
        wr(ADDR_CAP1_LOW, 8'hAA, RESP_OKAY);
        rd(ADDR_CAP1_LOW, 8'hFF, 8'h01);
        u_pins.ext_pulses(1);
        u_pins.cap_toggle(0);
        rd(ADDR_STATUS, 8'h80, 8'h00);
        u_pins.cap_toggle(0);
        rd(ADDR_CAP1_LOW, 8'hFF, 8'h02);
        rd(ADDR_STATUS, 8'h80, 8'h80);
        rd(ADDR_CAP2_HIGH, 8'h00, 8'h00);
        u_pins.cap_toggle(1);
        rd(ADDR_STATUS, 8'h10, 8'h00);
        rd(ADDR_CAP2_LOW, 8'h00, 8'h00);
        u_pins.cap_toggle(1);
        u_pins.cap_toggle(1);
        rd(ADDR_CAP2_LOW, 8'hFF, 8'h02);
        wr(ADDR_CMP2_LOW, 8'h04, RESP_OKAY);
        wr(ADDR_CMP2_HIGH, 8'h00, RESP_OKAY);
        s_axi_wstrb <= 4'hE;
        wr(ADDR_CMP2_LOW, 8'h77, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(ADDR_CMP2_LOW, 8'hFF, 8'h04);
        wr(ADDR_CMP1_HIGH, 8'h00, RESP_OKAY);
        rd(ADDR_STATUS, 8'h00, 8'h00);
        wr(ADDR_CMP1_LOW, 8'h04, RESP_OKAY);
        wr(ADDR_CONTROL_ONE, 8'h43, RESP_OKAY);
        rd(ADDR_CONTROL_ONE, 8'hFF, 8'h43);
        wr(ADDR_CONTROL_TWO, 8'h8E, RESP_OKAY);
        u_pins.ext_pulses(2);
        rd(ADDR_STATUS, 8'h48, 8'h40);
        chk({27'h0, timer_irq, compare_output_pin_oe, compare_output_pin}, 32'h15);
        cpu_irq_mask <= 1'b1;
        repeat (3) @(posedge aclk);
        chk({31'h0, timer_irq}, 32'h0);
        cpu_irq_mask <= 1'b0;
        u_pins.ext_pulses(1);
        rd(ADDR_CMP1_LOW, 8'hFF, 8'h04);
        rd(ADDR_STATUS, 8'h40, 8'h00);
        chk({27'h0, timer_irq, compare_output_pin_oe, compare_output_pin}, 32'h05);
        wr(ADDR_CONTROL_TWO, 8'hAE, RESP_OKAY);
        u_pins.cap_toggle(0);
        u_pins.cap_toggle(0);
        rd(ADDR_CAP1_LOW, 8'hFF, 8'h02);
        u_pins.cap_toggle(1);
        u_pins.cap_toggle(1);
        rd(ADDR_CAP2_LOW, 8'hFF, 8'h05);
        wr(ADDR_CONTROL_TWO, 8'h04, RESP_OKAY);
        wr(ADDR_CNT_LOW, 8'h00, RESP_OKAY);
        @(posedge aclk);
        rd(ADDR_CNT_LOW, 8'hFF, 8'hFE);
        wr(ADDR_CONTROL_TWO, 8'h08, RESP_OKAY);
        wr(ADDR_CNT_LOW, 8'h00, RESP_OKAY);
        repeat (5) @(posedge aclk);
        rd(ADDR_CNT_LOW, 8'hFF, 8'hFD);
        conclude();
    end
endmodule : testbench
